//--- src/scbb_bridge.sv
// Purpose: bridge processor remote bus cycles onto peripheral card bus words
// Assumes: remote bus request already demultiplexed into address/data ports
// Notes:   one cycle in flight; remote ack only after the card cycle ends
`timescale 1ns/1ps
`default_nettype none

module scbb_bridge #(
	parameter int CARDS = scbb_pkg::CARD_COUNT
) (
	input  wire logic                 clock_i,
	input  wire logic                 rst_n_i,
	// processor remote bus side
	input  wire logic                 remote_read_req_i,
	input  wire logic                 remote_write_req_i,
	input  wire logic [1:0]           remote_size_i,
	input  wire logic [2:0]           remote_card_i,
	input  wire logic [6:1]           remote_addr_i,
	input  wire logic [3:0]           remote_addr_parity_i,
	input  wire logic [15:0]          remote_wdata_i,
	input  wire logic [1:0]           remote_wdata_parity_i,
	input  wire logic                 remote_timeout_i,
	input  wire logic                 io_timer_run_i,
	output logic                      remote_bus_ack_o,
	output logic                      remote_invalid_o,
	output logic [15:0]               remote_rdata_o,
	output logic [1:0]                remote_rdata_parity_o,
	// peripheral card bus side
	output logic [6:1]                card_addr_o,
	output logic                      card_addr_parity_o,
	output logic [15:0]               card_data_o,
	output logic                      card_data_oe_o,
	input  wire logic [15:0]          card_data_i,
	output logic                      card_data_parity_high_o,
	output logic                      card_data_parity_low_o,
	input  wire logic                 card_data_parity_high_i,
	input  wire logic                 card_data_parity_low_i,
	output logic                      card_read_strobe_o,
	output logic                      card_write_strobe_o,
	output logic [CARDS-1:0]          card_select_o,
	input  wire logic [CARDS-1:0]     card_wait_i,
	// status
	output logic [CARDS-1:0]          card_ready_status_o,
	output logic                      select_fault_o,
	output logic                      remote_parity_error_o,
	output logic                      card_parity_error_o
);

	// ************************************************************
	// input synchronisers for card pins
	// ************************************************************
	logic [CARDS-1:0] wait_s1;
	logic [CARDS-1:0] wait_s2;
	logic [CARDS-1:0] wait_s3;
	logic [15:0]      rd_s1;
	logic [15:0]      rd_s2;
	logic [15:0]      rd_s3;
	logic [1:0]       rp_s1;
	logic [1:0]       rp_s2;
	logic [1:0]       rp_s3;
	logic [CARDS-1:0] wait_q;

	// three stages; a wait change counts once stages two and three agree, data is taken from stage three
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wait_s1 <= '0;
			wait_s2 <= '0;
			wait_s3 <= '0;
			rd_s1   <= '0;
			rd_s2   <= '0;
			rd_s3   <= '0;
			rp_s1   <= '0;
			rp_s2   <= '0;
			rp_s3   <= '0;
		end
		else
		begin
			wait_s1 <= card_wait_i;
			wait_s2 <= wait_s1;
			wait_s3 <= wait_s2;
			rd_s1   <= card_data_i;
			rd_s2   <= rd_s1;
			rd_s3   <= rd_s2;
			rp_s1   <= {card_data_parity_high_i, card_data_parity_low_i};
			rp_s2   <= rp_s1;
			rp_s3   <= rp_s2;
		end
	end

	// filtered wait: bit moves only where stages two and three agree
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			wait_q <= '0;
		else
			wait_q <= (wait_s2 & wait_s3) | (wait_q & (wait_s2 | wait_s3));
	end

	// ************************************************************
	// parity helpers
	// ************************************************************
	logic addr_odd;
	logic wd_even_hi;
	logic wd_even_lo;
	logic rd_even_hi;
	logic rd_even_lo;

	scbb_parity #(.WIDTH(6)) u_addr_par (
		.data_i (remote_addr_i),
		.even_o (),
		.odd_o  (addr_odd)
	);
	scbb_parity #(.WIDTH(8)) u_wd_hi (
		.data_i (remote_wdata_i[15:8]),
		.even_o (wd_even_hi),
		.odd_o  ()
	);
	scbb_parity #(.WIDTH(8)) u_wd_lo (
		.data_i (remote_wdata_i[7:0]),
		.even_o (wd_even_lo),
		.odd_o  ()
	);
	scbb_parity #(.WIDTH(8)) u_rd_hi (
		.data_i (rd_s3[15:8]),
		.even_o (rd_even_hi),
		.odd_o  ()
	);
	scbb_parity #(.WIDTH(8)) u_rd_lo (
		.data_i (rd_s3[7:0]),
		.even_o (rd_even_lo),
		.odd_o  ()
	);

	// remote address byte parity is odd over the byte holding the address
	logic addr_par_bad;
	logic wdata_par_bad;
	assign addr_par_bad  = (remote_addr_parity_i[0] != addr_odd);
	assign wdata_par_bad = remote_write_req_i &&
		((remote_wdata_parity_i[1] != wd_even_hi) ||
		 (remote_wdata_parity_i[0] != wd_even_lo));

	// ************************************************************
	// cycle sequencer
	// ************************************************************
	scbb_pkg::scbb_state_t state;
	logic [3:0]            setup_cnt;
	logic                  is_write;
	logic                  invalid;
	logic [2:0]            target;
	logic                  req;

	// only word-sized requests are bridged; others are refused
	assign req = (remote_read_req_i ^ remote_write_req_i) &&
		(remote_size_i == scbb_pkg::SIZE_WORD);

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state     <= scbb_pkg::SCBB_IDLE;
			setup_cnt <= '0;
			is_write  <= 1'b0;
			invalid   <= 1'b0;
			target    <= '0;
		end
		else if (remote_timeout_i && state != scbb_pkg::SCBB_IDLE)
			state <= scbb_pkg::SCBB_IDLE;
		else
		begin
			case (state)
				scbb_pkg::SCBB_IDLE:
					if (req && io_timer_run_i)
					begin
						is_write  <= remote_write_req_i;
						invalid   <= addr_par_bad | wdata_par_bad;
						target    <= remote_card_i;
						setup_cnt <= scbb_pkg::SETUP_CNT;
						state     <= scbb_pkg::SCBB_SETUP;
					end
				scbb_pkg::SCBB_SETUP:
					if (setup_cnt <= 4'h1)
						state <= scbb_pkg::SCBB_WAIT;
					else
						setup_cnt <= setup_cnt - 4'h1;
				scbb_pkg::SCBB_WAIT:
					if (!wait_q[target])
						state <= scbb_pkg::SCBB_DONE;
				scbb_pkg::SCBB_DONE:
					// hold until requester drops, one cycle at a time
					if (!(remote_read_req_i | remote_write_req_i))
						state <= scbb_pkg::SCBB_IDLE;
				default:
					state <= scbb_pkg::SCBB_IDLE;
			endcase
		end
	end

	logic cycle_end;
	logic active;
	assign cycle_end = (state == scbb_pkg::SCBB_WAIT) &&
		(!wait_q[target] || remote_timeout_i);
	// card leads fall on the edge that raises the ack, so the two never overlap
	assign active = ((state == scbb_pkg::SCBB_SETUP) || (state == scbb_pkg::SCBB_WAIT)) &&
		!cycle_end;

	// ************************************************************
	// card bus drive, held stable across the whole cycle
	// ************************************************************
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			card_addr_o             <= '0;
			card_addr_parity_o      <= 1'b1;
			card_data_o             <= '0;
			card_data_parity_high_o <= 1'b0;
			card_data_parity_low_o  <= 1'b0;
		end
		else if (state == scbb_pkg::SCBB_IDLE && req && io_timer_run_i)
		begin
			card_addr_o             <= remote_addr_i;
			card_addr_parity_o      <= addr_odd;
			card_data_o             <= remote_wdata_i;
			card_data_parity_high_o <= wd_even_hi;
			card_data_parity_low_o  <= wd_even_lo;
		end
	end

	// strobes and select; an invalid write drives no write strobe
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			card_read_strobe_o  <= 1'b0;
			card_write_strobe_o <= 1'b0;
			card_data_oe_o      <= 1'b0;
			card_select_o       <= '0;
		end
		else
		begin
			card_read_strobe_o  <= active && !is_write && !remote_timeout_i;
			card_write_strobe_o <= active && is_write && !invalid && !remote_timeout_i;
			card_data_oe_o      <= active && is_write && !invalid && !remote_timeout_i;
			card_select_o       <= (active && !remote_timeout_i && !(is_write && invalid))
				? CARDS'(1) << target : '0;
		end
	end

	// ************************************************************
	// remote answer
	// ************************************************************
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			remote_bus_ack_o      <= 1'b0;
			remote_invalid_o      <= 1'b0;
			remote_rdata_o        <= '0;
			remote_rdata_parity_o <= '0;
		end
		else
		begin
			remote_bus_ack_o <= (state == scbb_pkg::SCBB_WAIT && !wait_q[target] &&
				!remote_timeout_i);
			if (state == scbb_pkg::SCBB_WAIT && !wait_q[target])
			begin
				remote_invalid_o <= invalid;
				if (!is_write)
				begin
					remote_rdata_o        <= rd_s3;
					remote_rdata_parity_o <= rp_s3;
				end
			end
		end
	end

	// ************************************************************
	// status: ready snapshot and sticky errors
	// ************************************************************
	// snapshot of every wait line at the end of each card cycle that reaches the wait phase
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			card_ready_status_o <= CARDS'(scbb_pkg::READY_RESET);
		else if (cycle_end)
			card_ready_status_o <= wait_q;
	end

	// popcount above one on the driven selects; errors stay until reset
	function automatic logic multi_hot(input logic [CARDS-1:0] v);
		multi_hot = (v & (v - CARDS'(1))) != '0;
	endfunction

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			select_fault_o        <= 1'b0;
			remote_parity_error_o <= 1'b0;
			card_parity_error_o   <= 1'b0;
		end
		else
		begin
			if (multi_hot(card_select_o))
				select_fault_o <= 1'b1;
			if (state == scbb_pkg::SCBB_IDLE && req && io_timer_run_i &&
				(addr_par_bad | wdata_par_bad))
				remote_parity_error_o <= 1'b1;
			if (state == scbb_pkg::SCBB_WAIT && !wait_q[target] && !is_write &&
				((rp_s3[1] != rd_even_hi) || (rp_s3[0] != rd_even_lo)))
				card_parity_error_o <= 1'b1;
		end
	end

	// card interrupt leads are routed elsewhere and have no port here
endmodule

`default_nettype wire

//--- inc/scbb_pkg.sv
// Purpose: shared constants for the peripheral card bus bridge
// Assumes: single clock at 125 MHz, active-low asynchronous reset
// Notes:   card bus timing counts are in clock cycles
package scbb_pkg;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int CARD_DATA_W   = 16;
	localparam int CARD_ADDR_W   = 6;
	localparam int CARD_COUNT    = 8;
	localparam int REMOTE_W      = 32;

	// ************************************************************
	// remote bus size encodings
	// ************************************************************
	localparam logic [1:0] SIZE_WORD = 2'h1;

	// ************************************************************
	// card bus timing, in clock cycles
	// ************************************************************
	localparam int CLOCK_MHZ        = 125;
	localparam int SETUP_NS         = 40;
	localparam int SETUP_CYCLES     = (SETUP_NS * CLOCK_MHZ + 999) / 1000;
	localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYCLES);

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] READY_RESET = 8'h00;

	// ************************************************************
	// bridge states
	// ************************************************************
	typedef enum logic [2:0] {
		SCBB_IDLE,
		SCBB_SETUP,
		SCBB_WAIT,
		SCBB_DONE
	} scbb_state_t;

endpackage

//--- src/scbb_parity.sv
// Purpose: byte parity helper for the peripheral card bus bridge
// Assumes: pure combinational
// Notes:   odd output is the complement of even
`timescale 1ns/1ps
`default_nettype none

module scbb_parity #(
	parameter int WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] data_i,
	output logic                  even_o,
	output logic                  odd_o
);

	// even parity bit makes total ones even; odd parity bit makes total odd
	assign even_o = ^data_i;
	assign odd_o  = ~(^data_i);

endmodule

`default_nettype wire

//--- dv/scbb_chk.sv
// Purpose: port protocol checks for the card bus bridge
// Assumes: one clock, async active-low reset
// Notes:   bound onto every bridge instance
`timescale 1ns/1ps
`default_nettype none
module scbb_chk #(
	parameter int CARDS = scbb_pkg::CARD_COUNT
) (
	input wire logic             clock_i,
	input wire logic             rst_n_i,
	input wire logic             io_timer_run_i,
	input wire logic             remote_timeout_i,
	input wire logic             remote_bus_ack_o,
	input wire logic             remote_invalid_o,
	input wire logic             remote_parity_error_o,
	input wire logic [6:1]       card_addr_o,
	input wire logic             card_addr_parity_o,
	input wire logic [15:0]      card_data_o,
	input wire logic             card_data_oe_o,
	input wire logic             card_data_parity_high_o,
	input wire logic             card_data_parity_low_o,
	input wire logic             card_read_strobe_o,
	input wire logic             card_write_strobe_o,
	input wire logic [CARDS-1:0] card_select_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	logic stb;
	// either strobe marks a card cycle in flight
	assign stb = card_read_strobe_o | card_write_strobe_o;
	// ****
	// cycle shape
	// ****
	sequence s_setup;
		stb[*5];
	endsequence
	sequence s_abort;
		##[0:4] remote_timeout_i;
	endsequence
	property p_setup;
		$rose(stb) |-> s_setup or s_abort;
	endproperty
	a_setup: assert property (p_setup) else $error("strobe cut short");
	property p_hold;
		stb && $past(stb) |-> $stable(card_addr_o) && $stable(card_data_o) && $stable(card_select_o);
	endproperty
	a_hold: assert property (p_hold) else $error("card outputs moved");
	property p_one_sel;
		$onehot0(card_select_o) && (stb == (card_select_o != '0));
	endproperty
	a_one_sel: assert property (p_one_sel) else $error("select mismatch");
	property p_excl;
		!(card_read_strobe_o && card_write_strobe_o);
	endproperty
	a_excl: assert property (p_excl) else $error("both strobes");
	property p_timer;
		$rose(stb) |-> $past(io_timer_run_i, 2);
	endproperty
	a_timer: assert property (p_timer) else $error("start with timer off");
	property p_ack;
		remote_bus_ack_o |-> !stb ##1 !remote_bus_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack shape wrong");
	property p_late_ack;
		remote_bus_ack_o && !remote_invalid_o |-> $past(stb);
	endproperty
	a_late_ack: assert property (p_late_ack) else $error("ack without card cycle");
	property p_addr_par;
		card_addr_parity_o == ~^card_addr_o;
	endproperty
	a_addr_par: assert property (p_addr_par) else $error("address parity");
	property p_data_par;
		card_data_oe_o |-> card_data_parity_high_o == ^card_data_o[15:8]
			&& card_data_parity_low_o == ^card_data_o[7:0];
	endproperty
	a_data_par: assert property (p_data_par) else $error("data parity");
	property p_abort;
		remote_timeout_i && stb |=> !stb && !remote_bus_ack_o;
	endproperty
	a_abort: assert property (p_abort) else $error("timeout not aborted");
	property p_sticky;
		remote_parity_error_o |=> remote_parity_error_o;
	endproperty
	a_sticky: assert property (p_sticky) else $error("error flag lost");
endmodule
bind scbb_bridge scbb_chk #(.CARDS(CARDS)) u_scbb_chk (.clock_i, .rst_n_i, .io_timer_run_i,
	.remote_timeout_i, .remote_bus_ack_o, .remote_invalid_o, .remote_parity_error_o,
	.card_addr_o, .card_addr_parity_o, .card_data_o, .card_data_oe_o,
	.card_data_parity_high_o, .card_data_parity_low_o, .card_read_strobe_o,
	.card_write_strobe_o, .card_select_o);
`default_nettype wire

//--- dv/scbb_card_model.sv
// Purpose: behavioural card set on the far side of the bridge
// Assumes: cards answer from a small word store
// Notes:   idle data toggles so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module scbb_card_model (
	input  wire logic        clock_i,
	input  wire logic [7:0]  sel_i,
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	input  wire logic [6:1]  addr_i,
	input  wire logic [15:0] data_i,
	input  wire logic [7:0]  wait_len_i,
	input  wire logic [7:0]  stuck_i,
	input  wire logic        bad_i,
	output logic      [7:0]  wait_o,
	output logic      [15:0] data_o,
	output logic      [1:0]  par_o
);
	logic [15:0] mem [8][64];
	logic [15:0] last = 16'h0000;
	logic [7:0]  cnt;
	logic [2:0]  idx;
	// decode the active select
	always_comb
	begin
		idx = 3'h0;
		for (int k = 0; k < 8; k++)
			if (sel_i[k])
				idx = 3'(k);
	end
	// stall for the set count; a stuck card never lets go
	always_comb
		for (int k = 0; k < 8; k++)
			wait_o[k] = (sel_i[k] && cnt < wait_len_i) || stuck_i[k];
	// read data with even byte parity, high byte spoilt on demand
	assign data_o = (rd_i && sel_i != 8'h00) ? mem[idx][addr_i] : ~last;
	assign par_o = {^data_o[15:8] ^ bad_i, ^data_o[7:0]};
	always @(posedge clock_i)
	begin
		last <= data_o;
		cnt <= (sel_i == 8'h00) ? 8'h00 : cnt + 8'h01;
		if (wr_i && sel_i != 8'h00)
			mem[idx][addr_i] <= data_i;
	end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Purpose: self-checking bench for the card bus bridge
// Assumes: card model on the far side
// Notes:   requests change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clock_i, rst_n_i, remote_read_req_i, remote_write_req_i, remote_timeout_i;
	logic io_timer_run_i, remote_bus_ack_o, remote_invalid_o, card_data_oe_o;
	logic card_addr_parity_o, card_data_parity_high_o, card_data_parity_low_o;
	logic card_data_parity_high_i, card_data_parity_low_i, card_read_strobe_o;
	logic card_write_strobe_o, select_fault_o, remote_parity_error_o, card_parity_error_o;
	logic [1:0] remote_size_i, remote_wdata_parity_i, remote_rdata_parity_o, mpar, rpv;
	logic [2:0] remote_card_i;
	logic [3:0] remote_addr_parity_i;
	logic [6:1] remote_addr_i, card_addr_o;
	logic [15:0] remote_wdata_i, remote_rdata_o, card_data_o, card_data_i, mdata, rdv;
	logic [7:0] card_select_o, card_wait_i, card_ready_status_o, wlen, stuck;
	logic bad, got, inv;
	int failures, n_checks;
	logic [24:0] rows [3] = '{{3'h0, 6'h01, 16'hA5C3}, {3'h7, 6'h3F, 16'h0001},
		{3'h3, 6'h2A, 16'hFFFF}};
	scbb_bridge u_scbb_bridge (.*);
	scbb_card_model u_scbb_card_model (.clock_i, .sel_i(card_select_o),
		.rd_i(card_read_strobe_o), .wr_i(card_write_strobe_o), .addr_i(card_addr_o),
		.data_i(card_data_o), .wait_len_i(wlen), .stuck_i(stuck), .bad_i(bad),
		.wait_o(card_wait_i), .data_o(mdata), .par_o(mpar));
	// shared data wire: whoever enables drives
	assign card_data_i = card_data_oe_o ? card_data_o : mdata;
	assign card_data_parity_high_i = card_data_oe_o ? card_data_parity_high_o : mpar[1];
	assign card_data_parity_low_i = card_data_oe_o ? card_data_parity_low_o : mpar[0];
	initial
	begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e)
		begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic final_report;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one remote cycle; held until ack or bound, a missing wanted ack ends the run
	task automatic xfer(input logic w, input logic [24:0] r, input logic pe,
		input logic abort, input logic want);
		@(negedge clock_i);
		remote_write_req_i = w;
		remote_read_req_i = !w;
		{remote_card_i, remote_addr_i, remote_wdata_i} = r;
		remote_addr_parity_i = {3'h0, pe ^ ~^r[21:16]};
		remote_wdata_parity_i = {^r[15:8], ^r[7:0]};
		got = 1'b0;
		// an abort gives up early; the processor timeout then ends the cycle
		for (int n = 0; n < (abort ? 30 : 60) && !got; n++)
		begin
			@(negedge clock_i);
			got = remote_bus_ack_o;
			rdv = remote_rdata_o;
			rpv = remote_rdata_parity_o;
			inv = remote_invalid_o;
		end
		remote_read_req_i = 1'b0;
		remote_write_req_i = 1'b0;
		remote_timeout_i = abort;
		@(negedge clock_i);
		remote_timeout_i = 1'b0;
		if (want && got !== 1'b1)
		begin
			failures++;
			final_report();
		end
	endtask
	initial
	begin
		failures = 0;
		n_checks = 0;
		rst_n_i = 1'b0;
		remote_read_req_i = 1'b0;
		remote_write_req_i = 1'b0;
		remote_timeout_i = 1'b0;
		io_timer_run_i = 1'b1;
		remote_size_i = scbb_pkg::SIZE_WORD;
		{remote_card_i, remote_addr_i, remote_wdata_i} = 25'h0;
		{remote_addr_parity_i, remote_wdata_parity_i} = 6'h0;
		{wlen, stuck, bad} = 17'h0;
		repeat (8) @(negedge clock_i);
		chk(card_addr_parity_o, 1'b1);
		chk({card_select_o, card_read_strobe_o, card_write_strobe_o}, 10'h0);
		chk({remote_bus_ack_o, remote_invalid_o, remote_parity_error_o, card_parity_error_o}, 16'h0);
		chk({card_ready_status_o, card_data_oe_o, select_fault_o}, 16'h0);
		rst_n_i = 1'b1;
		repeat (4) @(negedge clock_i);
		// writes with growing stalls, then read back
		for (int i = 0; i < 3; i++)
		begin
			wlen = 8'(i * 4);
			xfer(1'b1, rows[i], 1'b0, 1'b0, 1'b1);
			chk(inv, 1'b0);
		end
		for (int i = 0; i < 3; i++)
		begin
			xfer(1'b0, rows[i], 1'b0, 1'b0, 1'b1);
			chk(rdv, rows[i][15:0]);
			chk(rpv, {^rows[i][15:8], ^rows[i][7:0]});
			chk(card_ready_status_o, 8'h00);
		end
		// bad address parity: flagged, store untouched
		xfer(1'b1, {rows[0][24:16], 16'h1234}, 1'b1, 1'b0, 1'b1);
		chk({inv, remote_parity_error_o}, 2'h3);
		xfer(1'b0, rows[0], 1'b0, 1'b0, 1'b1);
		chk(rdv, rows[0][15:0]);
		xfer(1'b0, rows[2], 1'b1, 1'b0, 1'b1);
		chk(inv, 1'b1);
		// spoilt card parity is passed on and flagged
		bad = 1'b1;
		xfer(1'b0, rows[1], 1'b0, 1'b0, 1'b1);
		bad = 1'b0;
		chk(rpv, {~^rows[1][15:8], ^rows[1][7:0]});
		chk(card_parity_error_o, 1'b1);
		// stopped timer and long size start nothing
		io_timer_run_i = 1'b0;
		xfer(1'b1, rows[2], 1'b0, 1'b0, 1'b0);
		chk(got, 1'b0);
		io_timer_run_i = 1'b1;
		remote_size_i = 2'h2;
		xfer(1'b1, rows[2], 1'b0, 1'b0, 1'b0);
		chk(got, 1'b0);
		remote_size_i = scbb_pkg::SIZE_WORD;
		// stuck card: timeout aborts, next snapshot names it
		stuck = 8'h20;
		xfer(1'b0, {3'h5, 22'h0}, 1'b0, 1'b1, 1'b0);
		chk(got, 1'b0);
		chk(card_ready_status_o, 8'h20);
		xfer(1'b0, rows[0], 1'b0, 1'b0, 1'b1);
		chk(card_ready_status_o, 8'h20);
		chk(card_addr_o, rows[0][21:16]);
		chk(card_data_o, rows[0][15:0]);
		stuck = 8'h00;
		chk(select_fault_o, 1'b0);
		final_report();
	end
endmodule
`default_nettype wire
